//--- logic/ccr_pkg.sv
/*
  constants, field layouts, reset values and carrier types for the
  channel calibration register slice (channel 4 offset/gain, channel 5
  configuration and upper offset).
  assumes one 16-bit register per printed address on a plain strobe port,
  and a calibration datapath fed with 24-bit samples on the same clock.
*/
// Summary of operation
// - ch4 offset bits 23:8 in upper register
// - ch4 offset bits 7:0 high byte; low zero
// - offset word applied as signed value
// - ch4 gain bits 23:8 in upper register
// - gain is unsigned fraction, midscale is unity
// - gain upper resets 8000h, lower zero
// - ch4 gain bits 7:0 high byte; low zero
// - ch5 delay: signed 10 bits, resets zero
// - ch5 bit 2 bypasses highpass, else global
// - ch5 bits 1:0 choose input routing
// - ch5 config bits 5:3 read zero
// - ch5 offset bits 23:8 upper, resets zero
package ccr_pkg;

  // bus and word geometry
  localparam int CCR_ADDR_W = 6;
  localparam int CCR_DATA_W = 16;
  localparam int CCR_WORD_W = 24;
  localparam int CCR_LOW_W = 8;
  localparam int CCR_DELAY_W = 10;
  localparam int CCR_HP_W = 4;

  // register addresses
  localparam logic [5:0] CCR_OFS_CH4_OFFSET_HIGH = 6'h1E;
  localparam logic [5:0] CCR_OFS_CH4_OFFSET_LOW = 6'h1F;
  localparam logic [5:0] CCR_OFS_CH4_GAIN_HIGH = 6'h20;
  localparam logic [5:0] CCR_OFS_CH4_GAIN_LOW = 6'h21;
  localparam logic [5:0] CCR_OFS_CH5_CONFIG = 6'h22;
  localparam logic [5:0] CCR_OFS_CH5_OFFSET_HIGH = 6'h23;

  // reset values
  localparam logic [15:0] CCR_RST_OFFSET_HIGH = 16'h0000;
  localparam logic [15:0] CCR_RST_OFFSET_LOW = 16'h0000;
  localparam logic [15:0] CCR_RST_GAIN_HIGH = 16'h8000;
  localparam logic [15:0] CCR_RST_GAIN_LOW = 16'h0000;
  localparam logic [15:0] CCR_RST_CONFIG = 16'h0000;

  // writable bit masks
  localparam logic [15:0] CCR_MASK_FULL = 16'hFFFF;
  localparam logic [15:0] CCR_MASK_LOW_WORD = 16'hFF00;
  localparam logic [15:0] CCR_MASK_CONFIG = 16'hFFC7;

  // channel 5 configuration field positions
  localparam int CCR_CFG_DELAY_LSB = 6;
  localparam int CCR_CFG_DELAY_MSB = 15;
  localparam int CCR_CFG_BYPASS_BIT = 2;
  localparam int CCR_CFG_SEL_LSB = 0;
  localparam int CCR_CFG_SEL_MSB = 1;
  localparam int CCR_LOW_FIELD_LSB = 8;

  // channel 5 input routing codes
  localparam logic [1:0] CCR_SEL_PINS = 2'h0;
  localparam logic [1:0] CCR_SEL_SHORT = 2'h1;
  localparam logic [1:0] CCR_SEL_TEST_POS = 2'h2;
  localparam logic [1:0] CCR_SEL_TEST_NEG = 2'h3;

  // register port request
  typedef struct packed {
    logic [CCR_ADDR_W-1:0] addr;
    logic [CCR_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ccr_bus_req_type;

  // one conversion sample
  typedef struct packed {
    logic valid;
    logic [CCR_WORD_W-1:0] data;
  } ccr_sample_type;

  // decoded channel 5 input routing, one hot
  typedef struct packed {
    logic pins;
    logic shorted;
    logic test_pos;
    logic test_neg;
  } ccr_route_type;

endpackage

//--- logic/ccr_route.sv
/*
  channel 5 input routing decoder: turns the two-bit selection into one
  switch control per path.
  assumes the selection comes from the bus write data or a register on the same clock.
*/
module ccr_route (
  // selection code
  input wire logic [1:0] chan5_input_select,
  // decoded switches
  output ccr_pkg::ccr_route_type route
);
  import ccr_pkg::*;

  // exactly one path closed for every code
  always_comb begin
    route = '0;
    unique case (chan5_input_select)
      CCR_SEL_PINS: route.pins = 1'b1;
      CCR_SEL_SHORT: route.shorted = 1'b1;
      CCR_SEL_TEST_POS: route.test_pos = 1'b1;
      CCR_SEL_TEST_NEG: route.test_neg = 1'b1;
    endcase
  end
endmodule

//--- logic/ccr_cal.sv
/*
  one-channel calibration stage: adds a signed offset, then scales by an
  unsigned gain whose midscale code is unity, saturating to the word range.
  assumes offset and gain are stable registers on the same clock; one
  cycle of latency from in_valid to out_valid.
*/
module ccr_cal #(
  parameter int WORD_W = 24
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // calibration words
  input wire logic [WORD_W-1:0] offset,
  input wire logic [WORD_W-1:0] gain,
  // raw sample
  input wire logic in_valid,
  input wire logic [WORD_W-1:0] in_data,
  // corrected sample
  output logic out_valid,
  output logic [WORD_W-1:0] out_data
);
  import ccr_pkg::*;

  // refuse widths the arithmetic cannot serve
  if (WORD_W < 2) begin : g_bad_width
    $error("ccr_cal: WORD_W must be at least 2");
  end

  localparam int PROD_W = 2 * WORD_W + 1;

  // registered output copy
  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } ccr_cal_state_type;

  ccr_cal_state_type st;
  ccr_cal_state_type next_st;

  // clamp a wide signed value into the signed word range
  function automatic logic [WORD_W-1:0] clip(input logic signed [PROD_W-1:0] v);
    logic signed [PROD_W-1:0] top;
    logic signed [PROD_W-1:0] bottom;
    top = PROD_W'(signed'({1'b0, {(WORD_W-1){1'b1}}}));
    bottom = -top - PROD_W'(1);
    if (v > top) begin
      clip = {1'b0, {(WORD_W-1){1'b1}}};
    end else if (v < bottom) begin
      clip = {1'b1, {(WORD_W-1){1'b0}}};
    end else begin
      clip = v[WORD_W-1:0];
    end
  endfunction

  // offset then gain, both saturated
  always_comb begin
    logic signed [PROD_W-1:0] sum_wide;
    logic signed [PROD_W-1:0] prod_wide;
    logic signed [WORD_W:0] gain_signed;
    logic signed [WORD_W-1:0] sum_clip;
    sum_wide = '0;
    prod_wide = '0;
    gain_signed = '0;
    sum_clip = '0;
    next_st = st;
    // sample and offset both two's complement
    sum_wide = PROD_W'(signed'(in_data)) + PROD_W'(signed'(offset));
    sum_clip = signed'(clip(sum_wide));
    // gain zero-extended, so its full code range is 0.0 to under 2.0
    gain_signed = signed'({1'b0, gain});
    // widen both factors first so the product keeps all its bits
    prod_wide = PROD_W'(sum_clip) * PROD_W'(gain_signed);
    // midscale gain code is unity, so drop WORD_W-1 fraction bits
    prod_wide = prod_wide >>> (WORD_W - 1);
    next_st.valid = in_valid;
    if (in_valid) begin
      next_st.data = clip(prod_wide);
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_valid = st.valid;
  assign out_data = st.data;
endmodule

//--- logic/ccr_regs.sv
/*
  channel calibration register slice: six 16-bit registers on a plain
  strobe port, the assembled channel 4 and channel 5 calibration words,
  the channel 5 delay, highpass and routing controls, and the correction
  of incoming samples of both channels.
  assumes the register master drives one-cycle strobes, never both at
  once, and that samples and the global highpass setting come from logic
  on clk_sys. read data stand only in the cycle after the read strobe.
*/
module ccr_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input ccr_pkg::ccr_bus_req_type bus_req,
  output logic [ccr_pkg::CCR_DATA_W-1:0] bus_rdata,
  // device-wide highpass setting, same clock
  input wire logic [ccr_pkg::CCR_HP_W-1:0] global_highpass_setting,
  // raw samples
  input ccr_pkg::ccr_sample_type chan4_raw,
  input ccr_pkg::ccr_sample_type chan5_raw,
  // corrected samples
  output ccr_pkg::ccr_sample_type chan4_corrected,
  output ccr_pkg::ccr_sample_type chan5_corrected,
  // channel 5 controls
  output logic signed [ccr_pkg::CCR_DELAY_W-1:0] chan5_delay_steps,
  output logic [ccr_pkg::CCR_HP_W-1:0] chan5_highpass_setting,
  output ccr_pkg::ccr_route_type chan5_route
);
  import ccr_pkg::*;

  // all state of the slice
  typedef struct packed {
    logic [CCR_DATA_W-1:0] channel4_offset_high;
    logic [CCR_DATA_W-1:0] channel4_offset_low;
    logic [CCR_DATA_W-1:0] channel4_gain_high;
    logic [CCR_DATA_W-1:0] channel4_gain_low;
    logic [CCR_DATA_W-1:0] channel5_config;
    logic [CCR_DATA_W-1:0] channel5_offset_high;
    logic [CCR_DATA_W-1:0] rdata;
    logic [CCR_DELAY_W-1:0] delay;
    logic [CCR_HP_W-1:0] highpass;
    ccr_route_type route;
  } ccr_regs_state_type;

  // reset image of the whole state
  localparam ccr_regs_state_type CCR_RESET_STATE = '{
    channel4_offset_high: CCR_RST_OFFSET_HIGH,
    channel4_offset_low: CCR_RST_OFFSET_LOW,
    channel4_gain_high: CCR_RST_GAIN_HIGH,
    channel4_gain_low: CCR_RST_GAIN_LOW,
    channel5_config: CCR_RST_CONFIG,
    channel5_offset_high: CCR_RST_OFFSET_HIGH,
    rdata: '0,
    delay: '0,
    highpass: '0,
    route: '{pins: 1'b1, shorted: 1'b0, test_pos: 1'b0, test_neg: 1'b0}
  };

  ccr_regs_state_type st;
  ccr_regs_state_type next_st;

  // assembled calibration words
  logic [CCR_WORD_W-1:0] chan4_offset_word;
  logic [CCR_WORD_W-1:0] chan4_gain_word;
  logic [CCR_WORD_W-1:0] chan5_offset_word;
  logic [CCR_WORD_W-1:0] unity_gain_word;
  // routing decoded from the next config value
  ccr_route_type next_route;
  // selection the config register holds after this edge
  logic [1:0] next_select;

  // write strobe aimed at one address
  function automatic logic write_hit(input ccr_bus_req_type req, input logic [5:0] ofs);
    write_hit = req.wr && (req.addr == ofs);
  endfunction

  // keep writable bits from the bus, force reserved bits to zero
  function automatic logic [CCR_DATA_W-1:0] masked(input logic [CCR_DATA_W-1:0] data,
                                                     input logic [CCR_DATA_W-1:0] mask);
    masked = data & mask;
  endfunction

  // write, read and control path
  always_comb begin
    next_st = st;
    // upper offset holds all sixteen bits
    if (write_hit(bus_req, CCR_OFS_CH4_OFFSET_HIGH)) begin
      next_st.channel4_offset_high = masked(bus_req.wdata, CCR_MASK_FULL);
    end
    // lower offset keeps only its high byte
    if (write_hit(bus_req, CCR_OFS_CH4_OFFSET_LOW)) begin
      next_st.channel4_offset_low = masked(bus_req.wdata, CCR_MASK_LOW_WORD);
    end
    // upper gain holds all sixteen bits
    if (write_hit(bus_req, CCR_OFS_CH4_GAIN_HIGH)) begin
      next_st.channel4_gain_high = masked(bus_req.wdata, CCR_MASK_FULL);
    end
    // lower gain keeps only its high byte
    if (write_hit(bus_req, CCR_OFS_CH4_GAIN_LOW)) begin
      next_st.channel4_gain_low = masked(bus_req.wdata, CCR_MASK_LOW_WORD);
    end
    // config drops bits 5:3
    if (write_hit(bus_req, CCR_OFS_CH5_CONFIG)) begin
      next_st.channel5_config = masked(bus_req.wdata, CCR_MASK_CONFIG);
    end
    // channel 5 upper offset holds all sixteen bits
    if (write_hit(bus_req, CCR_OFS_CH5_OFFSET_HIGH)) begin
      next_st.channel5_offset_high = masked(bus_req.wdata, CCR_MASK_FULL);
    end
    // read data for one cycle only, zero otherwise
    next_st.rdata = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        CCR_OFS_CH4_OFFSET_HIGH: next_st.rdata = st.channel4_offset_high;
        CCR_OFS_CH4_OFFSET_LOW: next_st.rdata = st.channel4_offset_low;
        CCR_OFS_CH4_GAIN_HIGH: next_st.rdata = st.channel4_gain_high;
        CCR_OFS_CH4_GAIN_LOW: next_st.rdata = st.channel4_gain_low;
        CCR_OFS_CH5_CONFIG: next_st.rdata = st.channel5_config;
        CCR_OFS_CH5_OFFSET_HIGH: next_st.rdata = st.channel5_offset_high;
        // unmapped addresses answer zero
        default: next_st.rdata = '0;
      endcase
    end
    // delay field, two's complement modulator cycles
    next_st.delay = next_st.channel5_config[CCR_CFG_DELAY_MSB:CCR_CFG_DELAY_LSB];
    // bypass forces the filter off, else the global setting governs
    if (next_st.channel5_config[CCR_CFG_BYPASS_BIT]) begin
      next_st.highpass = '0;
    end else begin
      next_st.highpass = global_highpass_setting;
    end
    // routing switches follow the selection field
    next_st.route = next_route;
  end

  // next selection taken from bus and register, not from next_st, so the
  // decode does not loop back through the state process
  assign next_select = write_hit(bus_req, CCR_OFS_CH5_CONFIG)
                     ? bus_req.wdata[CCR_CFG_SEL_MSB:CCR_CFG_SEL_LSB]
                     : st.channel5_config[CCR_CFG_SEL_MSB:CCR_CFG_SEL_LSB];

  // routing decode of the next selection
  ccr_route u_route (
    .chan5_input_select(next_select),
    .route(next_route)
  );

  // state register, synchronous reset to the documented image
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= CCR_RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // assemble 24-bit words: upper register then high byte of lower
  assign chan4_offset_word = {st.channel4_offset_high,
                              st.channel4_offset_low[CCR_DATA_W-1:CCR_LOW_FIELD_LSB]};
  assign chan4_gain_word = {st.channel4_gain_high,
                            st.channel4_gain_low[CCR_DATA_W-1:CCR_LOW_FIELD_LSB]};
  // lower channel 5 offset byte lives outside this slice
  assign chan5_offset_word = {st.channel5_offset_high, {CCR_LOW_W{1'b0}}};
  // channel 5 gain lives outside this slice, so unity here
  assign unity_gain_word = {CCR_RST_GAIN_HIGH, CCR_RST_GAIN_LOW[CCR_DATA_W-1:CCR_LOW_FIELD_LSB]};

  // channel 4 correction, signed offset then unsigned gain
  ccr_cal #(
    .WORD_W(CCR_WORD_W)
  ) u_cal4 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .offset(chan4_offset_word),
    .gain(chan4_gain_word),
    .in_valid(chan4_raw.valid),
    .in_data(chan4_raw.data),
    .out_valid(chan4_corrected.valid),
    .out_data(chan4_corrected.data)
  );

  // channel 5 correction, offset only
  ccr_cal #(
    .WORD_W(CCR_WORD_W)
  ) u_cal5 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .offset(chan5_offset_word),
    .gain(unity_gain_word),
    .in_valid(chan5_raw.valid),
    .in_data(chan5_raw.data),
    .out_valid(chan5_corrected.valid),
    .out_data(chan5_corrected.data)
  );

  // registered outputs
  assign bus_rdata = st.rdata;
  assign chan5_delay_steps = signed'(st.delay);
  assign chan5_highpass_setting = st.highpass;
  assign chan5_route = st.route;
endmodule

//--- bench/ccr_regs_assertions.sv
/*
  checker for the calibration register slice: readback of each register
  and the channel 5 control outputs against the written configuration.
  assumes it is bound to ccr_regs and sees only that module's ports.
*/
module ccr_regs_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input ccr_pkg::ccr_bus_req_type bus_req,
  input wire logic [ccr_pkg::CCR_DATA_W-1:0] bus_rdata,
  // channel 5 controls
  input wire logic [ccr_pkg::CCR_HP_W-1:0] global_highpass_setting,
  input wire logic signed [ccr_pkg::CCR_DELAY_W-1:0] chan5_delay_steps,
  input wire logic [ccr_pkg::CCR_HP_W-1:0] chan5_highpass_setting,
  input ccr_pkg::ccr_route_type chan5_route
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // short views of the request
  wire wr = bus_req.wr;
  wire rd = bus_req.rd;
  wire [5:0] ad = bus_req.addr;
  wire [15:0] wd = bus_req.wdata;

  // write followed at once by a read of the same register
  property p_ofs4_high;
    wr && ad == 6'h1E ##1 rd && ad == 6'h1E |=> bus_rdata == $past(wd, 2);
  endproperty
  a_ofs4_high: assert property (p_ofs4_high) else $error("ch4 offset high readback");
  property p_ofs4_low;
    wr && ad == 6'h1F ##1 rd && ad == 6'h1F |=> bus_rdata == ($past(wd, 2) & 16'hFF00);
  endproperty
  a_ofs4_low: assert property (p_ofs4_low) else $error("ch4 offset low readback");
  property p_gain4_high;
    wr && ad == 6'h20 ##1 rd && ad == 6'h20 |=> bus_rdata == $past(wd, 2);
  endproperty
  a_gain4_high: assert property (p_gain4_high) else $error("ch4 gain high readback");
  property p_gain4_low;
    wr && ad == 6'h21 ##1 rd && ad == 6'h21 |=> bus_rdata == ($past(wd, 2) & 16'hFF00);
  endproperty
  a_gain4_low: assert property (p_gain4_low) else $error("ch4 gain low readback");
  property p_cfg5;
    wr && ad == 6'h22 ##1 rd && ad == 6'h22 |=> bus_rdata == ($past(wd, 2) & 16'hFFC7);
  endproperty
  a_cfg5: assert property (p_cfg5) else $error("ch5 config readback");
  property p_ofs5_high;
    wr && ad == 6'h23 ##1 rd && ad == 6'h23 |=> bus_rdata == $past(wd, 2);
  endproperty
  a_ofs5_high: assert property (p_ofs5_high) else $error("ch5 offset high readback");
  // control outputs follow a config write
  property p_delay;
    wr && ad == 6'h22 |=> chan5_delay_steps == $past(wd[15:6]);
  endproperty
  a_delay: assert property (p_delay) else $error("ch5 delay field");
  property p_bypass;
    wr && ad == 6'h22 && wd[2] |=> chan5_highpass_setting == 4'h0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("ch5 highpass bypass");
  property p_hp_global;
    wr && ad == 6'h22 && !wd[2] ##1 !(wr && ad == 6'h22)
      |=> chan5_highpass_setting == $past(global_highpass_setting);
  endproperty
  a_hp_global: assert property (p_hp_global) else $error("ch5 highpass global");
  property p_route;
    wr && ad == 6'h22 |=> chan5_route == (4'h8 >> $past(wd[1:0]));
  endproperty
  a_route: assert property (p_route) else $error("ch5 input routing");
endmodule

bind ccr_regs ccr_regs_assertions chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .global_highpass_setting(global_highpass_setting), .chan5_delay_steps(chan5_delay_steps),
  .chan5_highpass_setting(chan5_highpass_setting), .chan5_route(chan5_route)
);

//--- bench/ccr_host.sv
/*
  host software model: one register access at a time on the strobe port.
  assumes the slice never stalls and answers a read one cycle later.
*/
module ccr_host (
  // clock
  input wire logic clk_sys,
  // register port
  output ccr_pkg::ccr_bus_req_type bus_req,
  input wire logic [ccr_pkg::CCR_DATA_W-1:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccr_pkg::*;
  // port idle until the first access
  initial bus_req = '0;
  // optional write, then optional read right behind it, no gap
  task automatic acc(input bit w, input bit r, input logic [5:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    if (w) begin
      @(posedge clk_sys);
      bus_req <= '{a, d, 1'b1, 1'b0};
    end
    if (r) begin
      @(posedge clk_sys);
      bus_req <= '{a, d, 1'b0, 1'b1};
    end
    // release: address and data show no stale value
    @(posedge clk_sys);
    bus_req <= '{~a, ~d, 1'b0, 1'b0};
    #1 q = bus_rdata;
  endtask
endmodule

//--- bench/ccr_regs_tb.sv
/*
  testbench for the calibration register slice: reset map, readback,
  channel 5 controls and sample correction, random with corner cases.
  assumes one 125 MHz clock and the host model on the register port.
*/
module ccr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccr_pkg::*;
  // clock, reset, counters
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // design inputs and outputs
  logic [CCR_HP_W-1:0] global_highpass_setting = '0;
  ccr_sample_type chan4_raw = '0;
  ccr_sample_type chan5_raw = '0;
  ccr_sample_type chan4_corrected, chan5_corrected;
  ccr_bus_req_type bus_req;
  logic [15:0] bus_rdata, q, d, o5;
  logic signed [CCR_DELAY_W-1:0] chan5_delay_steps;
  logic [CCR_HP_W-1:0] chan5_highpass_setting;
  ccr_route_type chan5_route;
  logic [23:0] ofs, gn, r4, r5;
  logic [5:0] ra [7] = '{6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h10};

  always #4 clk_sys = ~clk_sys;

  ccr_regs uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .global_highpass_setting(global_highpass_setting), .chan4_raw(chan4_raw),
    .chan5_raw(chan5_raw), .chan4_corrected(chan4_corrected),
    .chan5_corrected(chan5_corrected), .chan5_delay_steps(chan5_delay_steps),
    .chan5_highpass_setting(chan5_highpass_setting), .chan5_route(chan5_route)
  );
  ccr_host host (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata(bus_rdata));

  // count and report one comparison
  task check(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // verdict and end of run
  task final_report;
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // writable bits per address, unmapped reads zero
  function automatic logic [15:0] wmask(input logic [5:0] a);
    case (a)
      6'h1E, 6'h20, 6'h23: return 16'hFFFF;
      6'h1F, 6'h21: return 16'hFF00;
      6'h22: return 16'hFFC7;
      default: return 16'h0000;
    endcase
  endfunction
  // signed offset, clip, unsigned gain with midscale unity, clip
  function automatic logic [23:0] cal(input logic [23:0] raw, input logic [23:0] o,
                                      input logic [23:0] g);
    longint s;
    s = longint'($signed(raw)) + longint'($signed(o));
    if (s > 64'sh7FFFFF) s = 64'sh7FFFFF;
    if (s < -64'sh800000) s = -64'sh800000;
    s = (s * longint'(g)) >>> 23;
    if (s > 64'sh7FFFFF) s = 64'sh7FFFFF;
    if (s < -64'sh800000) s = -64'sh800000;
    return s[23:0];
  endfunction

  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'hB21B));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset map, unmapped address last
    for (int i = 0; i < 7; i++) begin
      host.acc(1'b0, 1'b1, ra[i], 16'h0000, q);
      check(q === (ra[i] == 6'h20 ? 16'h8000 : 16'h0000), "reset value");
    end
    check(chan5_route === 4'h8 && chan5_delay_steps === 10'h000, "reset ctl");
    // back to back write and read, all ones first
    for (int i = 0; i < 28; i++) begin
      d = (i < 7) ? 16'hFFFF : 16'($urandom);
      host.acc(1'b1, 1'b1, ra[i % 7], d, q);
      check(q === (d & wmask(ra[i % 7])), "readback");
    end
    // every routing code with and without bypass
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_sys);
      global_highpass_setting <= 4'($urandom);
      d = {10'($urandom), 3'($urandom), m[2], m[1:0]};
      host.acc(1'b1, 1'b0, 6'h22, d, q);
      @(posedge clk_sys);
      #1;
      check(chan5_route === (4'h8 >> m[1:0]), "route");
      check(chan5_delay_steps === d[15:6], "delay");
      check(chan5_highpass_setting === (m[2] ? 4'h0 : global_highpass_setting), "hp");
    end
    // sample correction, saturation and zero gain first
    for (int i = 0; i < 12; i++) begin
      ofs = (i == 0) ? 24'h7FFFFF : 24'($urandom);
      gn = (i == 1) ? 24'hFFFFFF : (i == 2) ? 24'h000000 : 24'($urandom);
      r4 = (i == 0) ? 24'h7FFFF0 : 24'($urandom);
      r5 = 24'($urandom);
      o5 = 16'($urandom);
      host.acc(1'b1, 1'b0, 6'h1E, ofs[23:8], q);
      host.acc(1'b1, 1'b0, 6'h1F, {ofs[7:0], 8'h00}, q);
      host.acc(1'b1, 1'b0, 6'h20, gn[23:8], q);
      host.acc(1'b1, 1'b0, 6'h21, {gn[7:0], 8'h00}, q);
      host.acc(1'b1, 1'b0, 6'h23, o5, q);
      @(posedge clk_sys);
      chan4_raw <= {1'b1, r4};
      chan5_raw <= {1'b1, r5};
      @(posedge clk_sys);
      chan4_raw.valid <= 1'b0;
      chan5_raw.valid <= 1'b0;
      #1;
      check(chan4_corrected === {1'b1, cal(r4, ofs, gn)}, "ch4 sample");
      check(chan5_corrected === {1'b1, cal(r5, {o5, 8'h00}, 24'h800000)}, "ch5");
    end
    final_report();
  end
endmodule
